/* verilog/dmc_pkg.sv */
// Shared constants and types of the audio converter mode-control bank.
// Assumes a single core clock domain plus the control-port shift clock.
package dmc_pkg;

  // Serial control word.
  localparam int WordBits = 16;
  localparam int IndexBits = 7;
  localparam int DataBits = 8;

  typedef struct packed {
    logic topBit;
    logic [IndexBits-1:0] registerIndex;
    logic [DataBits-1:0] data;
  } dmc_ctrl_word_t;

  // Register indices.
  localparam logic [IndexBits-1:0] IndexLeftAtten = 7'h10;
  localparam logic [IndexBits-1:0] IndexRightAtten = 7'h11;
  localparam logic [IndexBits-1:0] IndexMuteRate = 7'h12;
  localparam logic [IndexBits-1:0] IndexOutDeemph = 7'h13;
  localparam logic [IndexBits-1:0] IndexFormatFilter = 7'h14;
  localparam logic [IndexBits-1:0] IndexPhaseFlag = 7'h16;

  // Reset values.
  localparam logic [DataBits-1:0] ResetAtten = 8'hff;
  localparam logic [DataBits-1:0] ResetMuteRate = 8'h00;
  localparam logic [DataBits-1:0] ResetOutDeemph = 8'h00;
  localparam logic [DataBits-1:0] ResetFormatFilter = 8'h05;
  localparam logic [DataBits-1:0] ResetPhaseFlag = 8'h00;

  // Field positions.
  localparam int MuteLeftBit = 0;
  localparam int MuteRightBit = 1;
  localparam int OversampleBit = 6;
  localparam int DisableLeftBit = 0;
  localparam int DisableRightBit = 1;
  localparam int DeemphEnableBit = 4;
  localparam int DeemphRateLsb = 5;
  localparam int FormatLsb = 0;
  localparam int RolloffBit = 5;
  localparam int PhaseInvertBit = 0;
  localparam int FlagPolarityBit = 1;
  localparam int CommonFlagBit = 2;

  // Attenuator levels and timing in sample periods.
  localparam logic [DataBits-1:0] MuteLevel = 8'h80;
  localparam int RampPeriodSamples = 8;
  localparam int ZeroRunSamples = 1024;

  typedef enum logic [1:0] {
    DEEMPH_44K1 = 2'h0,
    DEEMPH_48K = 2'h1,
    DEEMPH_32K = 2'h2,
    DEEMPH_RESERVED = 2'h3
  } dmc_deemph_rate_t;

  typedef enum logic [2:0] {
    FMT_RIGHT24 = 3'h0,
    FMT_RIGHT20 = 3'h1,
    FMT_RIGHT18 = 3'h2,
    FMT_RIGHT16 = 3'h3,
    FMT_I2S = 3'h4,
    FMT_LEFT_JUSTIFIED = 3'h5,
    FMT_RESERVED6 = 3'h6,
    FMT_RESERVED7 = 3'h7
  } dmc_format_t;

  typedef struct packed {
    logic oversample128;
    logic [1:0] channelOutputDisable;
    logic deemphEnable;
    dmc_deemph_rate_t deemphRateSelect;
    dmc_format_t audioFormatSelect;
    logic rolloffSelect;
    logic outputPhaseInvert;
  } dmc_settings_t;

endpackage

/* verilog/dmc_channel_ramp.sv */
// One channel's stepped attenuator ramp and zero-run detector.
// Assumes sampleStrobe is a one-cycle pulse per sample period on core_clk.
`timescale 1ns/1ns
module dmc_channel_ramp
  import dmc_pkg::*;
#(
  parameter int RampPeriod = RampPeriodSamples,
  parameter int ZeroRun = ZeroRunSamples
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Controls
  input wire logic sampleStrobe,
  input wire logic [DataBits-1:0] programmedLevel,
  input wire logic softMute,
  input wire logic dataZero,
  // Status
  output logic [DataBits-1:0] appliedLevel,
  output logic muted,
  output logic zeroDetect
);

  localparam int RampBits = $clog2(RampPeriod);
  localparam int ZeroBits = $clog2(ZeroRun + 1);
  localparam logic [RampBits-1:0] RampLast = RampBits'(RampPeriod - 1);
  localparam logic [ZeroBits-1:0] ZeroLast = ZeroBits'(ZeroRun);

  logic [RampBits-1:0] rampCount;
  logic [ZeroBits-1:0] zeroCount;

  // Any value at or below the mute level is the same silent end point.
  wire logic [DataBits-1:0] clampedLevel = (programmedLevel < MuteLevel) ? MuteLevel
                                           : programmedLevel;
  wire logic [DataBits-1:0] targetLevel = softMute ? MuteLevel : clampedLevel;
  wire logic rampStep = sampleStrobe && (rampCount == RampLast);
  wire logic stepUp = appliedLevel < targetLevel;
  wire logic stepDown = appliedLevel > targetLevel;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rampCount <= '0;
    end else if (clkEn && sampleStrobe) begin
      rampCount <= rampCount + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      appliedLevel <= ResetAtten;
    end else if (clkEn && rampStep) begin
      if (stepUp) begin
        appliedLevel <= appliedLevel + 1'b1;
      end else if (stepDown) begin
        appliedLevel <= appliedLevel - 1'b1;
      end
    end
  end

  assign muted = appliedLevel <= MuteLevel;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      zeroCount <= '0;
    end else if (clkEn && sampleStrobe) begin
      if (!dataZero) begin
        zeroCount <= '0;
      end else if (zeroCount != ZeroLast) begin
        zeroCount <= zeroCount + 1'b1;
      end
    end
  end

  assign zeroDetect = zeroCount == ZeroLast;

endmodule

/* verilog/dmc_mode_control.sv */
// Mode-control register bank of a stereo audio converter, written over a
// three-wire serial port, with per-channel attenuation ramps and zero flags.
// Assumes the shift clock and latch follow the port timing, and that the
// sample clock and data-zero levels arrive from the audio clock domain.
//
// Notes on behaviour
// - Attenuation is half a dB times value minus 255; resets to 0xff.
// - Attenuation values 0 through 128 mean full mute.
// - Applied level steps one half dB per eight sample periods toward target.
// - Left uses index 0x10, right uses 0x11, programmed independently.
// - Soft mute ramps the attenuator down to mute, stepwise.
// - Releasing soft mute ramps back up to the programmed level.
// - Both soft-mute bits reset to zero.
// - Oversampling bit: zero is 64 times, one is 128 times; resets to zero.
// - A set output-disable bit holds that channel at bipolar zero.
// - De-emphasis enable bit switches de-emphasis on; resets off.
// - De-emphasis rate: 00 44.1k, 01 48k, 10 32k, 11 reserved.
// - Format field: right-justified, I2S, left-justified default; 110/111 reserved.
// - Rolloff bit: zero sharp, one slow; resets sharp.
// - Phase bit inverts both outputs; resets normal.
// - Flag polarity bit zero gives high flags, one gives low flags.
// - Common flag bit merges both flags onto one pin, other pin unassigned.
// - Words are sixteen bits, top bit zero, seven index bits, eight data.
// - Latch low, sixteen shift clocks, latch rising stores the word.
// - Zero detect after 1024 consecutive zero samples per channel.
`timescale 1ns/1ns
module dmc_mode_control
  import dmc_pkg::*;
#(
  parameter int RampPeriod = RampPeriodSamples,
  parameter int ZeroRun = ZeroRunSamples
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Serial control port
  input wire logic ctrlShiftClock,
  input wire logic ctrlSerialIn,
  input wire logic ctrlLatch,
  // Audio side status
  input wire logic sampleClock,
  input wire logic leftDataZero,
  input wire logic rightDataZero,
  // Settings to the datapath
  output dmc_settings_t settings,
  output logic [DataBits-1:0] leftAttenuationLevel,
  output logic [DataBits-1:0] rightAttenuationLevel,
  output logic leftMuted,
  output logic rightMuted,
  // Zero flag pins
  output logic leftSilenceFlag,
  output logic rightSilenceFlag
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_FRAME = 3'h2,
    ST_COMMIT = 3'h4
  } dmc_write_state_t;

  // ---------------- Link domain ----------------

  logic [WordBits-1:0] shiftWord;

  // Bits enter only while the latch is low, MSB first.
  always_ff @(posedge ctrlShiftClock or negedge arst_n) begin
    if (!arst_n) begin
      shiftWord <= '0;
    end else if (!ctrlLatch) begin
      shiftWord <= {shiftWord[WordBits-2:0], ctrlSerialIn};
    end
  end

  // ---------------- Core domain synchronisers ----------------

  // The latch, the sample clock and the data-zero levels all come from outside
  // the core clock domain. Each passes two flip-flops before any logic reads it,
  // and only the second stage feeds the edge detectors.
  // The latch stages reset high, its idle level, so that the release of reset
  // cannot be taken for a frame start.
  // The shift word itself is not synchronised: it is quiet while the latch is
  // high, and it is only sampled once the synchronised latch has risen.

  logic latchMeta;
  logic latchSync;
  logic latchPrev;
  logic sampleMeta;
  logic sampleSync;
  logic samplePrev;
  logic [1:0] zeroMeta;
  logic [1:0] zeroSync;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      latchMeta <= 1'b1;
      latchSync <= 1'b1;
      latchPrev <= 1'b1;
    end else if (clkEn) begin
      latchMeta <= ctrlLatch;
      latchSync <= latchMeta;
      latchPrev <= latchSync;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sampleMeta <= 1'b0;
      sampleSync <= 1'b0;
      samplePrev <= 1'b0;
    end else if (clkEn) begin
      sampleMeta <= sampleClock;
      sampleSync <= sampleMeta;
      samplePrev <= sampleSync;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      zeroMeta <= '0;
      zeroSync <= '0;
    end else if (clkEn) begin
      zeroMeta <= {rightDataZero, leftDataZero};
      zeroSync <= zeroMeta;
    end
  end

  wire logic latchFall = !latchSync && latchPrev;
  wire logic latchRise = latchSync && !latchPrev;
  wire logic sampleStrobe = sampleSync && !samplePrev;

  // ---------------- Write sequencing ----------------

  dmc_write_state_t writeState;
  dmc_write_state_t next_writeState;
  dmc_ctrl_word_t heldWord;

  always_comb begin
    next_writeState = writeState;
    unique case (writeState)
      ST_IDLE: begin
        if (latchFall) begin
          next_writeState = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (latchRise) begin
          next_writeState = ST_COMMIT;
        end
      end
      ST_COMMIT: begin
        next_writeState = ST_IDLE;
      end
      default: begin
        next_writeState = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      writeState <= ST_IDLE;
    end else if (clkEn) begin
      writeState <= next_writeState;
    end
  end

  // The shift word is quiet while the latch is high, so it is taken whole.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      heldWord <= '0;
    end else if (clkEn && writeState == ST_FRAME && latchRise) begin
      heldWord <= dmc_ctrl_word_t'(shiftWord);
    end
  end

  // A word with its top bit set is not a valid write and is dropped.
  wire logic commitValid = (writeState == ST_COMMIT) && !heldWord.topBit;
  wire logic [IndexBits-1:0] writeIndex = heldWord.registerIndex;
  wire logic [DataBits-1:0] writeData = heldWord.data;

  wire logic weLeftAtten = commitValid && writeIndex == IndexLeftAtten;
  wire logic weRightAtten = commitValid && writeIndex == IndexRightAtten;
  wire logic weMuteRate = commitValid && writeIndex == IndexMuteRate;
  wire logic weOutDeemph = commitValid && writeIndex == IndexOutDeemph;
  wire logic weFormatFilter = commitValid && writeIndex == IndexFormatFilter;
  wire logic wePhaseFlag = commitValid && writeIndex == IndexPhaseFlag;
  // Any other index, 0x15 included, falls through with no enable set.

  // ---------------- Register file ----------------

  // Each register is a plain byte that is written whole from one committed word.
  // No register can be read back over the port, so reserved bits are stored as
  // written and simply left unconnected to any setting.
  //
  // Left attenuation: the whole byte is the programmed level of the left channel.
  // Right attenuation: the whole byte is the programmed level of the right channel.
  // A level at or below the mute level is treated as the mute end point.
  //
  // Mute and rate control:
  //   bit 0 soft mute of the left channel,
  //   bit 1 soft mute of the right channel,
  //   bit 6 oversampling rate, 128 times when set.
  //
  // Output and de-emphasis control:
  //   bit 0 left output disable,
  //   bit 1 right output disable,
  //   bit 4 de-emphasis enable,
  //   bits 6 to 5 de-emphasis sample rate.
  //
  // Format and filter control:
  //   bits 2 to 0 audio data format,
  //   bit 5 slow rolloff when set.
  //
  // Phase and zero-flag control:
  //   bit 0 output phase inversion,
  //   bit 1 flag polarity inversion,
  //   bit 2 common flag on the right pin.
  //
  // Every write enable is a single-cycle pulse from the commit state, so a
  // register never sees two writes from one frame.

  logic [DataBits-1:0] leftAttenuation;
  logic [DataBits-1:0] rightAttenuation;
  logic [DataBits-1:0] muteAndRateControl;
  logic [DataBits-1:0] outputAndDeemphasisControl;
  logic [DataBits-1:0] formatAndFilterControl;
  logic [DataBits-1:0] phaseAndZeroFlagControl;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      leftAttenuation <= ResetAtten;
    end else if (clkEn && weLeftAtten) begin
      leftAttenuation <= writeData;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rightAttenuation <= ResetAtten;
    end else if (clkEn && weRightAtten) begin
      rightAttenuation <= writeData;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      muteAndRateControl <= ResetMuteRate;
    end else if (clkEn && weMuteRate) begin
      muteAndRateControl <= writeData;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      outputAndDeemphasisControl <= ResetOutDeemph;
    end else if (clkEn && weOutDeemph) begin
      outputAndDeemphasisControl <= writeData;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      formatAndFilterControl <= ResetFormatFilter;
    end else if (clkEn && weFormatFilter) begin
      formatAndFilterControl <= writeData;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseAndZeroFlagControl <= ResetPhaseFlag;
    end else if (clkEn && wePhaseFlag) begin
      phaseAndZeroFlagControl <= writeData;
    end
  end

  // ---------------- Field decode ----------------

  wire logic leftSoftMute = muteAndRateControl[MuteLeftBit];
  wire logic rightSoftMute = muteAndRateControl[MuteRightBit];
  wire logic flagPolarityInvert = phaseAndZeroFlagControl[FlagPolarityBit];
  wire logic commonFlagSelect = phaseAndZeroFlagControl[CommonFlagBit];

  assign settings.oversample128 = muteAndRateControl[OversampleBit];
  assign settings.channelOutputDisable = {outputAndDeemphasisControl[DisableRightBit],
                                          outputAndDeemphasisControl[DisableLeftBit]};
  assign settings.deemphEnable = outputAndDeemphasisControl[DeemphEnableBit];
  assign settings.deemphRateSelect =
    dmc_deemph_rate_t'(outputAndDeemphasisControl[DeemphRateLsb +: 2]);
  assign settings.audioFormatSelect =
    dmc_format_t'(formatAndFilterControl[FormatLsb +: 3]);
  assign settings.rolloffSelect = formatAndFilterControl[RolloffBit];
  assign settings.outputPhaseInvert = phaseAndZeroFlagControl[PhaseInvertBit];

  // ---------------- Channel attenuators ----------------

  logic [DataBits-1:0] programmedLevel [2];
  logic [DataBits-1:0] appliedLevel [2];
  logic [1:0] softMute;
  logic [1:0] mutedNow;
  logic [1:0] zeroDetect;

  assign programmedLevel[0] = leftAttenuation;
  assign programmedLevel[1] = rightAttenuation;
  assign softMute = {rightSoftMute, leftSoftMute};

  for (genvar ch = 0; ch < 2; ch++) begin : g_channel
    dmc_channel_ramp #(
      .RampPeriod(RampPeriod),
      .ZeroRun(ZeroRun)
    ) u_ramp (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .clkEn(clkEn),
      .sampleStrobe(sampleStrobe),
      .programmedLevel(programmedLevel[ch]),
      .softMute(softMute[ch]),
      .dataZero(zeroSync[ch]),
      .appliedLevel(appliedLevel[ch]),
      .muted(mutedNow[ch]),
      .zeroDetect(zeroDetect[ch])
    );
  end

  assign leftAttenuationLevel = appliedLevel[0];
  assign rightAttenuationLevel = appliedLevel[1];
  assign leftMuted = mutedNow[0];
  assign rightMuted = mutedNow[1];

  // ---------------- Zero flags ----------------

  // Flags are registered so that the pins never glitch while the detectors or
  // the flag settings change in the same cycle.

  wire logic sharedSilenceFlag = zeroDetect[0] && zeroDetect[1];
  // In common mode the left pin is unassigned and rests at its idle level.
  wire logic leftFlagActive = commonFlagSelect ? 1'b0 : zeroDetect[0];
  wire logic rightFlagActive = commonFlagSelect ? sharedSilenceFlag
                                                : zeroDetect[1];
  wire logic next_leftSilenceFlag = leftFlagActive ^ flagPolarityInvert;
  wire logic next_rightSilenceFlag = rightFlagActive ^ flagPolarityInvert;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      leftSilenceFlag <= 1'b0;
      rightSilenceFlag <= 1'b0;
    end else if (clkEn) begin
      leftSilenceFlag <= next_leftSilenceFlag;
      rightSilenceFlag <= next_rightSilenceFlag;
    end
  end

endmodule

/* dv/dmc_mode_control_chk.sv */
// Concurrent checks on the ports of the mode-control bank.
// Assumes one core clock domain; link pins are sampled raw on core_clk.
`timescale 1ns/1ns
module dmc_mode_control_chk
  import dmc_pkg::*;
#(
  parameter int RampPeriod = RampPeriodSamples,
  parameter int ZeroRun = ZeroRunSamples
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  // Serial control port
  input wire logic ctrlShiftClock,
  input wire logic ctrlSerialIn,
  input wire logic ctrlLatch,
  // Audio side status
  input wire logic sampleClock,
  input wire logic leftDataZero,
  input wire logic rightDataZero,
  // Design outputs
  input wire dmc_settings_t settings,
  input wire logic [DataBits-1:0] leftAttenuationLevel,
  input wire logic [DataBits-1:0] rightAttenuationLevel,
  input wire logic leftMuted,
  input wire logic rightMuted,
  input wire logic leftSilenceFlag,
  input wire logic rightSilenceFlag
);
  logic latchSeen;
  logic sampleSeen;
  logic [3:0] latchAge;
  logic [3:0] sampleAge;
  wire logic [3:0] next_latchAge;
  wire logic [3:0] next_sampleAge;

  // Ages count core edges since the raw rising edge of latch and sample clock.
  assign next_latchAge = (ctrlLatch && !latchSeen) ? 4'h0 :
                         (latchAge == 4'hf) ? latchAge : latchAge + 4'h1;
  assign next_sampleAge = (sampleClock && !sampleSeen) ? 4'h0 :
                          (sampleAge == 4'hf) ? sampleAge : sampleAge + 4'h1;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      latchSeen <= 1'b1;
      sampleSeen <= 1'b0;
      latchAge <= 4'hf;
      sampleAge <= 4'hf;
    end else begin
      latchSeen <= ctrlLatch;
      sampleSeen <= sampleClock;
      latchAge <= next_latchAge;
      sampleAge <= next_sampleAge;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_level_holds(logic [7:0] lvl);
    $stable(lvl) [*7];
  endsequence

  chk_left_step_one: assert property ($changed(leftAttenuationLevel) |->
    (leftAttenuationLevel == $past(leftAttenuationLevel) + 8'h1) ||
    (leftAttenuationLevel == $past(leftAttenuationLevel) - 8'h1))
    else $error("left level moved by more than one step");
  chk_left_step_gap: assert property ($changed(leftAttenuationLevel) |=>
    s_level_holds(leftAttenuationLevel))
    else $error("left level stepped twice too quickly");
  chk_right_step_one: assert property ($changed(rightAttenuationLevel) |->
    (rightAttenuationLevel == $past(rightAttenuationLevel) + 8'h1) ||
    (rightAttenuationLevel == $past(rightAttenuationLevel) - 8'h1))
    else $error("right level moved by more than one step");
  chk_right_step_gap: assert property ($changed(rightAttenuationLevel) |=>
    s_level_holds(rightAttenuationLevel))
    else $error("right level stepped twice too quickly");
  chk_left_mute_floor: assert property (leftAttenuationLevel >= 8'h80 &&
    leftMuted == (leftAttenuationLevel == 8'h80))
    else $error("left mute floor or muted flag wrong");
  chk_right_mute_floor: assert property (rightAttenuationLevel >= 8'h80 &&
    rightMuted == (rightAttenuationLevel == 8'h80))
    else $error("right mute floor or muted flag wrong");
  chk_settings_on_latch: assert property ($changed(settings) |->
    latchAge inside {[1:7]})
    else $error("settings changed without a latch rise");
  chk_level_on_sample: assert property (
    $changed({leftAttenuationLevel, rightAttenuationLevel}) |-> sampleAge inside {[1:6]})
    else $error("level changed away from a sample strobe");
  chk_flag_timing: assert property (
    $changed({leftSilenceFlag, rightSilenceFlag}) |->
    sampleAge inside {[1:6]} || latchAge inside {[1:8]})
    else $error("flag pin changed without cause");
endmodule

bind dmc_mode_control dmc_mode_control_chk #(
  .RampPeriod(RampPeriod),
  .ZeroRun(ZeroRun)
) dmc_mode_control_chk_inst (
  .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
  .ctrlShiftClock(ctrlShiftClock), .ctrlSerialIn(ctrlSerialIn), .ctrlLatch(ctrlLatch),
  .sampleClock(sampleClock), .leftDataZero(leftDataZero), .rightDataZero(rightDataZero),
  .settings(settings), .leftAttenuationLevel(leftAttenuationLevel),
  .rightAttenuationLevel(rightAttenuationLevel), .leftMuted(leftMuted),
  .rightMuted(rightMuted), .leftSilenceFlag(leftSilenceFlag),
  .rightSilenceFlag(rightSilenceFlag)
);

/* dv/dmc_host_model.sv */
// Host side of the three-wire control port, framing one word per call.
// Callers need not space calls apart; the task itself leaves the link idle for 200 ns.
`timescale 1ns/1ns
module dmc_host_model (
  // Link pins
  output logic ctrlShiftClock,
  output logic ctrlSerialIn,
  output logic ctrlLatch
);
  initial begin
    ctrlShiftClock = 1'b0;
    ctrlSerialIn = 1'b1;
    ctrlLatch = 1'b1;
  end

  // The shift clock runs only inside a frame, and data flips only after the latch rises, so the last bit is held past its edge.
  task automatic send(input logic [15:0] word);
    ctrlLatch = 1'b0;
    #23;
    for (int i = 15; i >= 0; i--) begin
      ctrlSerialIn = word[i];
      #8 ctrlShiftClock = 1'b1;
      #7 ctrlShiftClock = 1'b0;
    end
    #22 ctrlLatch = 1'b1;
    ctrlSerialIn = ~ctrlSerialIn;
    #200;
  endtask
endmodule

/* dv/tb_top.sv */
// Self-checking bench of the mode-control bank with a host model on the link.
// Assumes a short zero-run parameter; results are compared at note requests.
`timescale 1ns/1ns
module tb_top
  import dmc_pkg::*;
;
  typedef struct packed {
    dmc_settings_t set;
    logic [7:0] lv;
    logic [7:0] rv;
    logic [3:0] st;
  } dmc_tb_note_t;

  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic clkEn = 1'b1;
  logic sampleClock = 1'b0;
  logic leftDataZero = 1'b0;
  logic rightDataZero = 1'b0;
  logic ctrlShiftClock, ctrlSerialIn, ctrlLatch;
  dmc_settings_t settings;
  logic [7:0] leftAttenuationLevel, rightAttenuationLevel;
  logic leftMuted, rightMuted, leftSilenceFlag, rightSilenceFlag;
  dmc_tb_note_t notes[$];
  dmc_tb_note_t curNote;
  dmc_settings_t expSet;
  logic [7:0] expL, expR;
  logic [3:0] expSt;
  logic chkReq = 1'b0;
  logic [31:0] lfsrState = 32'h26af8997;
  int badCount = 0;
  int checksDone = 0;

  always #10 core_clk = ~core_clk;
  always begin
    repeat (4) @(posedge core_clk);
    #1 sampleClock = ~sampleClock;
  end

  dmc_host_model dmc_host_model_inst (.ctrlShiftClock(ctrlShiftClock),
    .ctrlSerialIn(ctrlSerialIn), .ctrlLatch(ctrlLatch));
  dmc_mode_control #(.RampPeriod(8), .ZeroRun(8)) dmc_mode_control_inst (
    .core_clk(core_clk), .arst_n(arst_n), .clkEn(clkEn),
    .ctrlShiftClock(ctrlShiftClock), .ctrlSerialIn(ctrlSerialIn), .ctrlLatch(ctrlLatch),
    .sampleClock(sampleClock), .leftDataZero(leftDataZero), .rightDataZero(rightDataZero),
    .settings(settings), .leftAttenuationLevel(leftAttenuationLevel),
    .rightAttenuationLevel(rightAttenuationLevel), .leftMuted(leftMuted),
    .rightMuted(rightMuted), .leftSilenceFlag(leftSilenceFlag),
    .rightSilenceFlag(rightSilenceFlag));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic closeOut;
    if (badCount == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic fail_line(input logic [15:0] got, input logic [15:0] exp);
    badCount++;
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
  endtask
  task automatic cmp_set(input dmc_settings_t got, input dmc_settings_t exp);
    checksDone++;
    if (got !== exp) fail_line(16'(got), 16'(exp));
  endtask
  task automatic cmp_lvl(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) fail_line({8'h00, got}, {8'h00, exp});
  endtask
  task automatic cmp_pins(input logic [3:0] got, input logic [3:0] exp);
    checksDone++;
    if (got !== exp) fail_line({12'h000, got}, {12'h000, exp});
  endtask

  always @(posedge core_clk) begin
    if (chkReq) begin
      curNote = notes.pop_front();
      cmp_set(settings, curNote.set);
      cmp_lvl(leftAttenuationLevel, curNote.lv);
      cmp_lvl(rightAttenuationLevel, curNote.rv);
      cmp_pins({leftMuted, rightMuted, leftSilenceFlag, rightSilenceFlag}, curNote.st);
    end
  end

  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    dmc_host_model_inst.send({1'b0, idx, d});
  endtask
  task automatic note;
    notes.push_back({expSet, expL, expR, expSt});
    @(posedge core_clk);
    #1 chkReq = 1'b1;
    @(posedge core_clk);
    #1 chkReq = 1'b0;
  endtask
  task automatic wait_samples(input int n);
    repeat (n) @(posedge sampleClock);
    repeat (8) @(posedge core_clk);
  endtask

  initial begin
    #1_000_000;
    badCount++;
    closeOut;
  end

  initial begin
    expSet = '0;
    expSet.audioFormatSelect = FMT_LEFT_JUSTIFIED;
    expL = 8'hff;
    expR = 8'hff;
    expSt = 4'h0;
    repeat (4) @(posedge core_clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    note;
    for (int f = 0; f < 6; f++) begin
      lfsrState = lfsr_next(lfsrState);
      expSet.audioFormatSelect = dmc_format_t'(f[2:0]);
      expSet.rolloffSelect = lfsrState[0];
      wr(IndexFormatFilter, {2'h0, lfsrState[0], 2'h0, f[2:0]});
      note;
    end
    for (int r = 0; r < 3; r++) begin
      lfsrState = lfsr_next(lfsrState);
      expSet.deemphRateSelect = dmc_deemph_rate_t'(r[1:0]);
      expSet.deemphEnable = lfsrState[4];
      expSet.channelOutputDisable = lfsrState[2:1];
      expSet.oversample128 = lfsrState[3];
      wr(IndexOutDeemph, {1'b0, r[1:0], lfsrState[4], 2'h0, lfsrState[2:1]});
      wr(IndexMuteRate, {1'b0, lfsrState[3], 6'h00});
      note;
    end
    expSet.outputPhaseInvert = 1'b1;
    wr(IndexPhaseFlag, 8'h01);
    note;
    wr(7'h15, 8'h00);
    dmc_host_model_inst.send({1'b1, IndexFormatFilter, 8'h03});
    note;
    wr(IndexLeftAtten, 8'hfd);
    wait_samples(40);
    expL = 8'hfd;
    note;
    wr(IndexLeftAtten, 8'h05);
    wr(IndexMuteRate, {1'b0, expSet.oversample128, 6'h02});
    wait_samples(1050);
    expL = 8'h80;
    expR = 8'h80;
    expSt = 4'hc;
    note;
    wr(IndexLeftAtten, 8'hff);
    wr(IndexMuteRate, {1'b0, expSet.oversample128, 6'h00});
    wait_samples(1050);
    expL = 8'hff;
    expR = 8'hff;
    expSt = 4'h0;
    note;
    leftDataZero = 1'b1;
    wait_samples(12);
    expSt = 4'h2;
    note;
    wr(IndexPhaseFlag, 8'h03);
    expSt = 4'h1;
    note;
    rightDataZero = 1'b1;
    wr(IndexPhaseFlag, 8'h07);
    wait_samples(12);
    expSt = 4'h2;
    note;
    leftDataZero = 1'b0;
    wait_samples(3);
    expSt = 4'h3;
    note;
    closeOut;
  end
endmodule
